// ### src/spc_port_ctrl.sv
// Two serial ports with per-port line settings, address filter and modem idle hang-up.
//
// Function
// - Protocol code: 0 off, 1 maker protocol, 2 Modbus ASCII, 3 Modbus RTU.
// - Protocol resets to 1 on port 1 and 3 on port 2.
// - Under Modbus the station address names the slave, valid 1 to 247.
// - Under the maker protocol the station address is ignored.
// - Line rate in kbaud; only 4.8, 9.6, 19.2, 115.2 supported, others flagged.
// - Line rate resets to 115.2 on port 1 and 19.2 on port 2.
// - Parity 0 none (reset), 1 odd, 2 even, on every character.
// - Character length 5 to 8 bits, reset 8.
// - One or two stop bits, reset one.
// - Modem setting 0 none (reset), 1 answer only.
// - Modem idle timeout programmable 0 to 9999 seconds.
// - Timeout acts only when the modem setting is 1.
// - Idle line until timeout commands the modem to hang up.
// - Timeout 0 disables the idle timer.
// - One global index placement bit, 0 global (reset), 1 parameter specific.
// - Settings are kept per port, global ones excepted.
// - Address filtering applies only on the multidrop port.
`timescale 1ns/1ps
`include "spc_regs.svh"

module spc_port_ctrl import spc_pkg::*; #(
  parameter int unsigned CYC_PER_SEC = `SPC_CYC_PER_SEC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] cfg_wr,
  input wire spc_cfg_s cfg_in,
  output spc_cfg_s [1:0] cfg_out,
  input wire logic index_placement_wr,
  input wire logic index_placement_in,
  output logic index_placement,
  output logic [1:0] port_active,
  output logic [1:0] rate_unsupported,
  output logic [1:0] txd,
  input wire logic [1:0] rxd,
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready,
  input wire logic [1:0][7:0] tx_data,
  output logic [1:0] rx_valid,
  output logic [1:0][7:0] rx_data,
  output logic [1:0] rx_error,
  output logic [1:0] rx_frame_start,
  output logic [1:0] rx_addr_ok,
  input wire logic [1:0] modem_carrier,
  output logic [1:0] modem_hang_up
);

  // Reset configuration of one port; port index 0 is the point-to-point port.
  function automatic spc_cfg_s spc_cfg_reset(input logic multidrop);
    spc_cfg_s c;
    c.port_protocol_select = multidrop ? `SPC_P2_PROTO : `SPC_P1_PROTO;
    c.station_address = `SPC_RST_ADDR;
    c.line_rate_select = multidrop ? `SPC_P2_RATE : `SPC_P1_RATE;
    c.parity_select = `SPC_RST_PAR;
    c.char_length = `SPC_RST_LEN;
    c.stop_bit_count = `SPC_RST_STOP;
    c.modem_present = `SPC_RST_MODEM;
    c.modem_idle_timeout = `SPC_RST_TMO;
    return c;
  endfunction : spc_cfg_reset

  // Value of one ASCII hex digit, 0-9 or upper case A-F; anything else reads as zero.
  function automatic logic [3:0] spc_hex(input logic [7:0] ch);
    logic [3:0] v;
    v = 4'h0;
    if (ch >= 8'h30 && ch <= 8'h39) begin
      v = ch[3:0];
    end else if (ch >= 8'h41 && ch <= 8'h46) begin
      v = ch[3:0] + 4'h9;
    end
    return v;
  endfunction : spc_hex

  // ****************************************************************
  // Global index placement setting
  // ****************************************************************
  logic index_q;
  logic index_d;

  // Single setting shared by both ports.
  always_comb begin
    index_d = index_placement_wr ? index_placement_in : index_q;
  end

  // Holds the placement bit.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      index_q <= `SPC_RST_INDEX;
    end else begin
      index_q <= index_d;
    end
  end

  assign index_placement = index_q;

  // ****************************************************************
  // Per-port configuration, character engine and modem control
  // ****************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_port
    spc_cfg_s cfg_q;
    spc_cfg_s cfg_d;
    spc_proto_e proto;
    logic [15:0] div;
    logic rate_ok;
    logic on;
    logic [2:0] last_bit;
    logic par_en;
    logic par_init;
    logic two_stop;
    logic [13:0] tmo;
    logic [21:0] gap_lim;

    // Each port keeps its own copy; a write strobe replaces it whole.
    always_comb begin
      cfg_d = cfg_wr[i] ? cfg_in : cfg_q;
    end

    // Holds the port settings with the per-port reset values.
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        cfg_q <= spc_cfg_reset(i == 1);
      end else begin
        cfg_q <= cfg_d;
      end
    end

    // Decodes the stored settings into engine controls.
    always_comb begin
      proto = spc_proto_e'(cfg_q.port_protocol_select);
      rate_ok = 1'b1;
      unique case (cfg_q.line_rate_select)
        `SPC_RATE_4K8: div = 16'(`SPC_BAUD_DIV(4800));
        `SPC_RATE_9K6: div = 16'(`SPC_BAUD_DIV(9600));
        `SPC_RATE_19K2: div = 16'(`SPC_BAUD_DIV(19200));
        `SPC_RATE_115K2: div = 16'(`SPC_BAUD_DIV(115200));
        default: begin
          div = 16'(`SPC_BAUD_DIV(115200));
          rate_ok = 1'b0;
        end
      endcase
      on = (proto != SPC_PROTO_OFF) && rate_ok;
      if (cfg_q.char_length >= `SPC_LEN_MIN && cfg_q.char_length <= `SPC_LEN_MAX) begin
        last_bit = 3'(cfg_q.char_length - 4'h1);
      end else begin
        last_bit = 3'h7;
      end
      par_en = (cfg_q.parity_select == `SPC_PAR_ODD) ||
               (cfg_q.parity_select == `SPC_PAR_EVEN);
      par_init = (cfg_q.parity_select == `SPC_PAR_ODD);
      two_stop = (cfg_q.stop_bit_count == `SPC_STOP_TWO);
      tmo = (cfg_q.modem_idle_timeout > `SPC_TMO_MAX) ? `SPC_TMO_MAX
                                                      : cfg_q.modem_idle_timeout;
      gap_lim = 22'({6'h00, div} * `SPC_GAP_BITS);
    end

    // ----- Transmit engine -----
    spc_tx_e tx_st_q;
    spc_tx_e tx_st_d;
    logic [15:0] tx_cnt_q;
    logic [15:0] tx_cnt_d;
    logic [2:0] tx_bit_q;
    logic [2:0] tx_bit_d;
    logic [7:0] tx_sh_q;
    logic [7:0] tx_sh_d;
    logic tx_par_q;
    logic tx_par_d;
    logic txd_q;
    logic txd_d;
    logic tx_take;

    // Frames each character bit by bit at the programmed rate.
    always_comb begin
      tx_st_d = tx_st_q;
      tx_cnt_d = tx_cnt_q - 16'h0001;
      tx_bit_d = tx_bit_q;
      tx_sh_d = tx_sh_q;
      tx_par_d = tx_par_q;
      txd_d = txd_q;
      tx_take = 1'b0;
      unique case (tx_st_q)
        SPC_TX_IDLE: begin
          txd_d = 1'b1;
          tx_cnt_d = div;
          if (tx_valid[i] && on) begin
            tx_take = 1'b1;
            tx_sh_d = tx_data[i];
            tx_par_d = par_init;
            txd_d = 1'b0;
            tx_st_d = SPC_TX_START;
          end
        end
        SPC_TX_START: begin
          if (tx_cnt_q == 16'h0001) begin
            tx_cnt_d = div;
            txd_d = tx_sh_q[0];
            tx_par_d = tx_par_q ^ tx_sh_q[0];
            tx_bit_d = 3'h0;
            tx_st_d = SPC_TX_DATA;
          end
        end
        SPC_TX_DATA: begin
          if (tx_cnt_q == 16'h0001) begin
            tx_cnt_d = div;
            if (tx_bit_q == last_bit) begin
              txd_d = par_en ? tx_par_q : 1'b1;
              tx_bit_d = 3'h0;
              tx_st_d = par_en ? SPC_TX_PAR : SPC_TX_STOP;
            end else begin
              tx_sh_d = {1'b0, tx_sh_q[7:1]};
              txd_d = tx_sh_q[1];
              tx_par_d = tx_par_q ^ tx_sh_q[1];
              tx_bit_d = tx_bit_q + 3'h1;
            end
          end
        end
        SPC_TX_PAR: begin
          if (tx_cnt_q == 16'h0001) begin
            tx_cnt_d = div;
            txd_d = 1'b1;
            tx_st_d = SPC_TX_STOP;
          end
        end
        SPC_TX_STOP: begin
          if (tx_cnt_q == 16'h0001) begin
            tx_cnt_d = div;
            if (two_stop && tx_bit_q == 3'h0) begin
              tx_bit_d = 3'h1;
            end else begin
              tx_st_d = SPC_TX_IDLE;
            end
          end
        end
      endcase
    end

    // Registers the transmit engine; the line idles high.
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        tx_st_q <= SPC_TX_IDLE;
        tx_cnt_q <= 16'h0000;
        tx_bit_q <= 3'h0;
        tx_sh_q <= 8'h00;
        tx_par_q <= 1'b0;
        txd_q <= 1'b1;
      end else begin
        tx_st_q <= tx_st_d;
        tx_cnt_q <= tx_cnt_d;
        tx_bit_q <= tx_bit_d;
        tx_sh_q <= tx_sh_d;
        tx_par_q <= tx_par_d;
        txd_q <= txd_d;
      end
    end

    // ----- Receive engine -----
    spc_rx_e rx_st_q;
    spc_rx_e rx_st_d;
    logic [15:0] rx_cnt_q;
    logic [15:0] rx_cnt_d;
    logic [2:0] rx_bit_q;
    logic [2:0] rx_bit_d;
    logic [7:0] rx_sh_q;
    logic [7:0] rx_sh_d;
    logic rx_par_q;
    logic rx_par_d;
    logic rx_perr_q;
    logic rx_perr_d;
    logic rx_vld_q;
    logic rx_vld_d;
    logic [7:0] rx_dat_q;
    logic [7:0] rx_dat_d;
    logic rx_err_q;
    logic rx_err_d;

    // Samples each bit at its centre, half a bit after the start edge.
    always_comb begin
      rx_st_d = rx_st_q;
      rx_cnt_d = rx_cnt_q - 16'h0001;
      rx_bit_d = rx_bit_q;
      rx_sh_d = rx_sh_q;
      rx_par_d = rx_par_q;
      rx_perr_d = rx_perr_q;
      rx_vld_d = 1'b0;
      rx_dat_d = rx_dat_q;
      rx_err_d = rx_err_q;
      unique case (rx_st_q)
        SPC_RX_IDLE: begin
          rx_cnt_d = {1'b0, div[15:1]};
          if (on && !rxd[i]) begin
            rx_st_d = SPC_RX_START;
          end
        end
        SPC_RX_START: begin
          if (rx_cnt_q == 16'h0001) begin
            rx_cnt_d = div;
            rx_bit_d = 3'h0;
            rx_par_d = par_init;
            rx_perr_d = 1'b0;
            rx_st_d = rxd[i] ? SPC_RX_IDLE : SPC_RX_DATA;
          end
        end
        SPC_RX_DATA: begin
          if (rx_cnt_q == 16'h0001) begin
            rx_cnt_d = div;
            rx_sh_d = {rxd[i], rx_sh_q[7:1]};
            rx_par_d = rx_par_q ^ rxd[i];
            rx_bit_d = rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit) begin
              rx_st_d = par_en ? SPC_RX_PAR : SPC_RX_STOP;
            end
          end
        end
        SPC_RX_PAR: begin
          if (rx_cnt_q == 16'h0001) begin
            rx_cnt_d = div;
            rx_perr_d = rx_par_q ^ rxd[i];
            rx_st_d = SPC_RX_STOP;
          end
        end
        SPC_RX_STOP: begin
          if (rx_cnt_q == 16'h0001) begin
            rx_vld_d = 1'b1;
            rx_dat_d = rx_sh_q >> (3'h7 - last_bit);
            rx_err_d = rx_perr_q || !rxd[i];
            rx_st_d = SPC_RX_IDLE;
          end
        end
      endcase
    end

    // Registers the receive engine and its character outputs.
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        rx_st_q <= SPC_RX_IDLE;
        rx_cnt_q <= 16'h0000;
        rx_bit_q <= 3'h0;
        rx_sh_q <= 8'h00;
        rx_par_q <= 1'b0;
        rx_perr_q <= 1'b0;
        rx_vld_q <= 1'b0;
        rx_dat_q <= 8'h00;
        rx_err_q <= 1'b0;
      end else begin
        rx_st_q <= rx_st_d;
        rx_cnt_q <= rx_cnt_d;
        rx_bit_q <= rx_bit_d;
        rx_sh_q <= rx_sh_d;
        rx_par_q <= rx_par_d;
        rx_perr_q <= rx_perr_d;
        rx_vld_q <= rx_vld_d;
        rx_dat_q <= rx_dat_d;
        rx_err_q <= rx_err_d;
      end
    end

    // ----- Frame start and station address filter -----
    logic [21:0] gap_q;
    logic [21:0] gap_d;
    logic quiet_q;
    logic quiet_d;
    logic [1:0] apos_q;
    logic [1:0] apos_d;
    logic [3:0] ahi_q;
    logic [3:0] ahi_d;
    logic aok_q;
    logic aok_d;
    logic first_q;
    logic first_d;
    logic [7:0] abyte;
    logic amatch;

    // RTU frames start after a silent gap; ASCII frames start at a colon.
    always_comb begin
      gap_d = gap_q;
      quiet_d = quiet_q;
      apos_d = apos_q;
      ahi_d = ahi_q;
      aok_d = aok_q;
      first_d = 1'b0;
      abyte = (proto == SPC_PROTO_ASCII) ? {ahi_q, spc_hex(rx_dat_q)} : rx_dat_q;
      amatch = (abyte == `SPC_ADDR_BCAST) ||
               (cfg_q.station_address >= `SPC_ADDR_MIN &&
                cfg_q.station_address <= `SPC_ADDR_MAX &&
                abyte == cfg_q.station_address[7:0]);
      if (rx_st_q != SPC_RX_IDLE) begin
        gap_d = 22'h00_0000;
      end else if (gap_q != gap_lim) begin
        gap_d = gap_q + 22'h00_0001;
      end
      if (rx_st_q == SPC_RX_IDLE && rx_st_d == SPC_RX_START) begin
        quiet_d = (gap_q == gap_lim);
      end
      if (rx_vld_q) begin
        if (proto == SPC_PROTO_RTU && quiet_q) begin
          first_d = 1'b1;
          aok_d = amatch;
        end else if (proto == SPC_PROTO_ASCII) begin
          if (rx_dat_q == `SPC_ASCII_COLON) begin
            first_d = 1'b1;
            aok_d = 1'b0;
            apos_d = 2'h1;
          end else if (apos_q == 2'h1) begin
            ahi_d = spc_hex(rx_dat_q);
            apos_d = 2'h2;
          end else if (apos_q == 2'h2) begin
            aok_d = amatch;
            apos_d = 2'h0;
          end
        end
      end
    end

    // Registers the frame tracking state.
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        gap_q <= 22'h00_0000;
        quiet_q <= 1'b0;
        apos_q <= 2'h0;
        ahi_q <= 4'h0;
        aok_q <= 1'b0;
        first_q <= 1'b0;
      end else begin
        gap_q <= gap_d;
        quiet_q <= quiet_d;
        apos_q <= apos_d;
        ahi_q <= ahi_d;
        aok_q <= aok_d;
        first_q <= first_d;
      end
    end

    // ----- Modem idle timeout and hang-up -----
    logic tmo_en;
    logic tmo_expire;
    logic hang_q;
    logic hang_d;

    // Timer runs only with an answer-only modem, a nonzero timeout and a live call.
    assign tmo_en = cfg_q.modem_present && (tmo != 14'h0000) && modem_carrier[i];

    spc_idle_timer #(
      .CYC_PER_SEC(CYC_PER_SEC)
    ) u_idle (
      .clk_sys(clk_sys),
      .rst(rst),
      .enable(tmo_en),
      .activity(tx_take || rx_vld_q),
      .timeout(tmo),
      .expire(tmo_expire)
    );

    // Hang-up holds until the carrier drops or the modem setting clears; a new expiry wins over the release.
    always_comb begin
      hang_d = hang_q;
      if (!modem_carrier[i] || !cfg_q.modem_present) begin
        hang_d = 1'b0;
      end
      if (tmo_expire) begin
        hang_d = 1'b1;
      end
    end

    // Registers the hang-up command.
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        hang_q <= 1'b0;
      end else begin
        hang_q <= hang_d;
      end
    end

    // ----- Port outputs -----
    assign cfg_out[i] = cfg_q;
    assign port_active[i] = on;
    assign rate_unsupported[i] = !rate_ok;
    assign txd[i] = txd_q;
    assign tx_ready[i] = (tx_st_q == SPC_TX_IDLE) && on;
    assign rx_valid[i] = rx_vld_q;
    assign rx_data[i] = rx_dat_q;
    assign rx_error[i] = rx_err_q;
    assign rx_frame_start[i] = first_q;
    // Only the multidrop port filters on address, under every protocol code but the maker protocol.
    assign rx_addr_ok[i] = (i == 0) || (proto == SPC_PROTO_MAKER) || aok_q;
    assign modem_hang_up[i] = hang_q;
  end

endmodule : spc_port_ctrl

// ### src/spc_regs.svh
// Constants for the serial port configuration and modem idle block.
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// ****************************************************************
// Clock and time base
// ****************************************************************
`define SPC_CLK_PERIOD_NS 8
`define SPC_CLK_HZ (1000000000 / `SPC_CLK_PERIOD_NS)
`define SPC_SEC_NS 1000000000
`define SPC_CYC_PER_SEC (`SPC_SEC_NS / `SPC_CLK_PERIOD_NS)
`define SPC_BAUD_DIV(baud) ((`SPC_CLK_HZ + ((baud) / 2)) / (baud))

// ****************************************************************
// Line rate codes, in tenths of a kbaud
// ****************************************************************
`define SPC_RATE_4K8 11'h030
`define SPC_RATE_9K6 11'h060
`define SPC_RATE_19K2 11'h0C0
`define SPC_RATE_115K2 11'h480

// ****************************************************************
// Limits and field values
// ****************************************************************
`define SPC_ADDR_MIN 14'h0001
`define SPC_ADDR_MAX 14'h00F7
`define SPC_ADDR_BCAST 8'h00
`define SPC_TMO_MAX 14'h270F
`define SPC_PAR_NONE 2'h0
`define SPC_PAR_ODD 2'h1
`define SPC_PAR_EVEN 2'h2
`define SPC_LEN_MIN 4'h5
`define SPC_LEN_MAX 4'h8
`define SPC_STOP_TWO 2'h2
`define SPC_GAP_BITS 22'h00_0027
`define SPC_ASCII_COLON 8'h3A

// ****************************************************************
// Reset values
// ****************************************************************
`define SPC_P1_PROTO 2'h1
`define SPC_P2_PROTO 2'h3
`define SPC_P1_RATE `SPC_RATE_115K2
`define SPC_P2_RATE `SPC_RATE_19K2
`define SPC_RST_ADDR 14'h0001
`define SPC_RST_PAR 2'h0
`define SPC_RST_LEN 4'h8
`define SPC_RST_STOP 2'h1
`define SPC_RST_MODEM 1'h0
`define SPC_RST_TMO 14'h0000
`define SPC_RST_INDEX 1'h0

`endif

// ### src/spc_pkg.sv
// Types shared by the serial port configuration block.
package spc_pkg;

  // ****************************************************************
  // Protocol codes, in selection code order
  // ****************************************************************
  typedef enum logic [1:0] {
    SPC_PROTO_OFF,
    SPC_PROTO_MAKER,
    SPC_PROTO_ASCII,
    SPC_PROTO_RTU
  } spc_proto_e;

  // ****************************************************************
  // Per-port configuration word
  // ****************************************************************
  typedef struct packed {
    logic [1:0] port_protocol_select;
    logic [13:0] station_address;
    logic [10:0] line_rate_select;
    logic [1:0] parity_select;
    logic [3:0] char_length;
    logic [1:0] stop_bit_count;
    logic modem_present;
    logic [13:0] modem_idle_timeout;
  } spc_cfg_s;

  // ****************************************************************
  // Character engine states
  // ****************************************************************
  typedef enum logic [2:0] {
    SPC_TX_IDLE,
    SPC_TX_START,
    SPC_TX_DATA,
    SPC_TX_PAR,
    SPC_TX_STOP
  } spc_tx_e;

  typedef enum logic [2:0] {
    SPC_RX_IDLE,
    SPC_RX_START,
    SPC_RX_DATA,
    SPC_RX_PAR,
    SPC_RX_STOP
  } spc_rx_e;

endpackage : spc_pkg

// ### src/spc_idle_timer.sv
// Modem inactivity timer that counts whole seconds of silence.
`timescale 1ns/1ps
`include "spc_regs.svh"

module spc_idle_timer import spc_pkg::*; #(
  parameter int unsigned CYC_PER_SEC = `SPC_CYC_PER_SEC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  input wire logic activity,
  input wire logic [13:0] timeout,
  output logic expire
);

  logic [31:0] sub_q;
  logic [31:0] sub_d;
  logic [13:0] sec_q;
  logic [13:0] sec_d;
  logic expire_q;
  logic expire_d;

  // ****************************************************************
  // Second divider and seconds counter
  // ****************************************************************

  // Activity restarts the whole count, so a timeout is T full seconds of silence.
  always_comb begin
    sub_d = sub_q;
    sec_d = sec_q;
    expire_d = 1'b0;
    if (!enable || activity) begin
      sub_d = 32'h0000_0000;
      sec_d = 14'h0000;
    end else if (sub_q == 32'(CYC_PER_SEC - 1)) begin
      sub_d = 32'h0000_0000;
      if (sec_q + 14'h0001 == timeout) begin
        expire_d = 1'b1;
        sec_d = 14'h0000;
      end else begin
        sec_d = sec_q + 14'h0001;
      end
    end else begin
      sub_d = sub_q + 32'h0000_0001;
    end
  end

  // Registers the count and the one-cycle expiry pulse.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sub_q <= 32'h0000_0000;
      sec_q <= 14'h0000;
      expire_q <= 1'b0;
    end else begin
      sub_q <= sub_d;
      sec_q <= sec_d;
      expire_q <= expire_d;
    end
  end

  assign expire = expire_q;

endmodule : spc_idle_timer

// ### test/spc_port_ctrl_checker.sv
// Port assertions for the serial port block.
`timescale 1ns/1ps
module spc_port_ctrl_checker import spc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] cfg_wr,
  input wire spc_cfg_s cfg_in,
  input wire spc_cfg_s [1:0] cfg_out,
  input wire logic index_placement_wr,
  input wire logic index_placement_in,
  input wire logic index_placement,
  input wire logic [1:0] port_active,
  input wire logic [1:0] rate_unsupported,
  input wire logic [1:0] txd,
  input wire logic [1:0] tx_valid,
  input wire logic [1:0] tx_ready,
  input wire logic [1:0] rx_addr_ok,
  input wire logic [1:0] modem_hang_up
);
  // All properties share one clock and reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A character taken on port 1.
  sequence s_acc;
    tx_valid[0] && tx_ready[0];
  endsequence
  // Two cycles of maker protocol on port 2.
  sequence s_maker;
    cfg_out[1].port_protocol_select == 2'h1 ##1 cfg_out[1].port_protocol_select == 2'h1;
  endsequence
  a_reset_vals: assert property ($fell(rst) |->
    cfg_out[0].port_protocol_select == 2'h1 && cfg_out[1].port_protocol_select == 2'h3
    && cfg_out[0].line_rate_select == 11'h480 && cfg_out[1].line_rate_select == 11'h0C0)
    else $error("bad reset cfg");
  a_cfg_store: assert property (cfg_wr[0] |=> cfg_out[0] == $past(cfg_in))
    else $error("cfg not stored");
  a_port_on: assert property (port_active[0] ==
    (cfg_out[0].port_protocol_select != 2'h0 && !rate_unsupported[0]))
    else $error("port enable wrong");
  a_tx_start: assert property (s_acc |=> !txd[0] && !tx_ready[0])
    else $error("no start bit");
  a_addr_p2p: assert property (!$past(rst) |-> rx_addr_ok[0])
    else $error("p2p filtered");
  a_maker_addr: assert property (s_maker |-> rx_addr_ok[1])
    else $error("maker filtered");
  a_hang_gate: assert property ($rose(modem_hang_up[0]) |->
    $past(cfg_out[0].modem_present) && $past(cfg_out[0].modem_idle_timeout) != 14'h0000)
    else $error("bad hang up");
  a_idx_store: assert property (index_placement_wr |=>
    index_placement == $past(index_placement_in)) else $error("index not stored");
endmodule : spc_port_ctrl_checker

bind spc_port_ctrl spc_port_ctrl_checker chk_u (.clk_sys, .rst, .cfg_wr, .cfg_in, .cfg_out,
  .index_placement_wr, .index_placement_in, .index_placement, .port_active,
  .rate_unsupported, .txd, .tx_valid, .tx_ready, .rx_addr_ok, .modem_hang_up);

// ### test/spc_master_model.sv
// Line master model that sends characters into a port receiver.
`timescale 1ns/1ps
module spc_master_model #(
  parameter int BIT = 1085
) (
  input wire logic clk_sys,
  output logic line
);
  initial line = 1'b1; // Marking level while idle.
  // Holds one bit on the line for a whole bit time.
  task automatic bit_out(input logic v);
    @(posedge clk_sys);
    #1 line = v;
    repeat (BIT - 1) @(posedge clk_sys);
  endtask : bit_out
  // Frames one character with the same settings as the port.
  task automatic send(input logic [7:0] b, input int ln, input int pa, input int st,
    input bit bad);
    bit_out(1'b0);
    for (int i = 0; i < ln; i++) bit_out(b[i]);
    if (pa != 0) bit_out(^b ^ (pa == 1) ^ bad);
    repeat (st) bit_out(1'b1);
  endtask : send
endmodule : spc_master_model

// ### test/spc_port_ctrl_tb_top.sv
// Self-checking bench for the serial port block.
`timescale 1ns/1ps
module spc_port_ctrl_tb_top import spc_pkg::*; ;
  localparam int D = 1085; // Cycles per bit at 115.2 kbaud.
  logic clk_sys, rst, idx_wr, idx_in, idx;
  logic [1:0] cfg_wr, tx_valid, carrier, txd, tx_ready, rx_valid, rx_error, act, uns, hang, fs;
  logic [1:0][7:0] tx_data, rx_data;
  spc_cfg_s cfg_in;
  spc_cfg_s [1:0] cfg_out;
  logic ser, bad;
  logic [8:0] q[$];
  logic [7:0] r, b;
  logic [8:0] got;
  logic [10:0] rt[5] = '{11'h07B, 11'h030, 11'h060, 11'h0C0, 11'h480};
  int fail_count = 0, checks = 0, nfs = 0, i, k, ln, pa, st;
  spc_port_ctrl #(.CYC_PER_SEC(100)) dut_u (.clk_sys, .rst, .cfg_wr, .cfg_in, .cfg_out,
    .index_placement_wr(idx_wr), .index_placement_in(idx_in), .index_placement(idx),
    .port_active(act), .rate_unsupported(uns), .txd, .rxd({1'b1, ser}), .tx_valid,
    .tx_ready, .tx_data, .rx_valid, .rx_data, .rx_error, .rx_frame_start(fs),
    .rx_addr_ok(), .modem_carrier(carrier), .modem_hang_up(hang));
  spc_master_model #(.BIT(D)) mst_u (.clk_sys, .line(ser));
  // Free running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Counts one comparison and reports a mismatch.
  task chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk
  // Prints the counts and the verdict.
  task end_sim;
    $display("checks=%0d fails=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Next pseudo random byte.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Builds a configuration word.
  function automatic spc_cfg_s mk(logic [1:0] pr, logic [10:0] ra, logic [1:0] p,
    logic [3:0] l, logic [1:0] s, logic mo, logic [13:0] tm);
    return '{pr, 14'h0001, ra, p, l, s, mo, tm};
  endfunction : mk
  // Writes one port's configuration.
  task wr(input int p, input spc_cfg_s v);
    @(posedge clk_sys);
    #1 cfg_in = v;
    cfg_wr[p] = 1'b1;
    @(posedge clk_sys);
    #1 cfg_wr = 2'b00;
  endtask : wr
  // Waits n cycles, staying off the sampling edge.
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // Compares every received character with the oldest note.
  always @(posedge clk_sys) begin
    if (rx_valid[0] === 1'b1) begin
      chk(q.size() > 0 && {rx_error[0], rx_data[0]} === q.pop_front(), "rx char");
    end
    if (fs[0] === 1'b1) nfs++;
  end
  // Cuts a hang short.
  initial begin
    cyc(90000);
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    end_sim;
  end
  initial begin
    rst = 1'b1; cfg_wr = 2'b00; cfg_in = '0; idx_wr = 1'b0; idx_in = 1'b0;
    tx_valid = 2'b00; tx_data = '0; carrier = 2'b00; r = 8'h38;
    cyc(10);
    rst = 1'b0;
    chk(cfg_out[0] === mk(2'h1, 11'h480, 2'h0, 4'h8, 2'h1, 1'b0, 14'h0000), "rst 1");
    chk(cfg_out[1] === mk(2'h3, 11'h0C0, 2'h0, 4'h8, 2'h1, 1'b0, 14'h0000), "rst 2");
    chk(idx === 1'b0, "idx rst");
    idx_wr = 1'b1; idx_in = 1'b1;
    cyc(1);
    idx_wr = 1'b0;
    cyc(1);
    chk(idx === 1'b1, "idx wr");
    wr(1, mk(2'h1, 11'h030, 2'h2, 4'h7, 2'h2, 1'b1, 14'h270F));
    chk(cfg_out[0] === mk(2'h1, 11'h480, 2'h0, 4'h8, 2'h1, 1'b0, 14'h0000), "kept");
    for (k = 0; k < 4; k++) for (i = 0; i < 5; i++) begin
      wr(0, mk(2'(k), rt[i], 2'h0, 4'h8, 2'h1, 1'b0, 14'h0000));
      chk(uns[0] === (i == 0) && act[0] === (k != 0 && i != 0), "rate");
    end
    $display("test config done");
    wr(0, mk(2'h1, 11'h480, 2'h0, 4'h8, 2'h1, 1'b1, 14'h0002));
    carrier = 2'b01;
    cyc(150);
    chk(hang[0] === 1'b0, "early hang");
    k = 0;
    while (hang[0] !== 1'b1 && k < 100) begin cyc(1); k++; end
    chk(hang[0] === 1'b1, "no hang");
    carrier = 2'b00;
    cyc(3);
    chk(hang[0] === 1'b0, "hang kept");
    carrier = 2'b01;
    wr(0, mk(2'h1, 11'h480, 2'h0, 4'h8, 2'h1, 1'b1, 14'h0000));
    cyc(400);
    chk(hang[0] === 1'b0, "tmo 0 hang");
    wr(0, mk(2'h1, 11'h480, 2'h0, 4'h8, 2'h1, 1'b0, 14'h0002));
    cyc(400);
    chk(hang[0] === 1'b0, "no modem hang");
    $display("test modem done");
    for (i = 0; i < 4; i++) begin
      ln = i == 1 ? 7 : (i == 2 ? 5 : 8);
      pa = i == 0 ? 0 : (i == 3 ? 2 : i);
      st = i == 2 ? 2 : 1;
      bad = i == 3;
      wr(0, mk(i == 1 ? 2'h2 : 2'h3, 11'h480, 2'(pa), 4'(ln), 2'(st), 1'b1, 14'h0096));
      r = lfsr(r);
      b = i == 1 ? 8'h3A : r & (8'hFF >> (8 - ln));
      q.push_back({bad, b});
      mst_u.send(b, ln, pa, st, bad);
    end
    cyc(D);
    chk(q.size() == 0, "rx lost");
    chk(nfs == 1, "frame start");
    chk(hang[0] === 1'b0, "idle hang");
    $display("test receive done");
    wr(0, mk(2'h3, 11'h480, 2'h2, 4'h8, 2'h1, 1'b0, 14'h0000));
    r = lfsr(r);
    tx_data[0] = r;
    tx_valid = 2'b01;
    k = 0;
    while (tx_ready[0] !== 1'b1 && k < 100) begin cyc(1); k++; end
    cyc(1);
    tx_valid = 2'b00;
    cyc(D / 2);
    chk(txd[0] === 1'b0, "start");
    for (i = 0; i < 9; i++) begin cyc(D - 1); got[i] = txd[0]; end
    chk(got === {^r, r}, "tx char");
    cyc(D - 1);
    chk(txd[0] === 1'b1, "stop");
    $display("test transmit done");
    end_sim;
  end
endmodule : spc_port_ctrl_tb_top
